// ===== design/phy_vsr_params.svh
// Register indices, field positions, reset values and timing counts of the vendor register bank
`ifndef PHY_VSR_PARAMS_SVH
`define PHY_VSR_PARAMS_SVH

// ==========================================================
// Register indices
`define IDX_SPECIAL_CTL 5'h1b
`define IDX_SRC_FLAGS 5'h1d
`define IDX_INT_MASK 5'h1e
`define IDX_PHY_SPECIAL 5'h1f

// ==========================================================
// Field positions
`define BIT_XOVER_OFF 15
`define BIT_MANUAL_SEL 13
`define BIT_HB_OFF 11
`define BIT_POL_REV 4
`define SRC_MSB 7
`define SRC_LSB 1
`define BIT_SRC_ENERGY 7
`define BIT_SRC_REMOTE 5
`define BIT_SRC_LINK_DOWN 4
`define BIT_SRC_PAGE 1
`define BIT_NEG_DONE 12
`define BIT_ENC_EN 6
`define SPD_MSB 4
`define SPD_LSB 2

// ==========================================================
// Reset values
`define RST_XOVER_OFF 1'b0
`define RST_MANUAL_SEL 1'b0
`define RST_HB_OFF 1'b0
`define RST_MASK 7'h00
`define RST_FLAGS 7'h00
`define RST_ENC_EN 1'b1
`define RST_LINE_ENERGY 1'b1
`define RST_WORD 16'h0000

// ==========================================================
// Timing: energy silence interval and its cycle count at the core clock
`define ENERGY_TIMEOUT_MS 256
`define CLK_FREQ_KHZ 10000
`define ENERGY_TIMEOUT_CYCLES (`ENERGY_TIMEOUT_MS * `CLK_FREQ_KHZ)

`endif

// ===== design/phy_vsr_pkg.sv
// Shared types of the vendor register bank
package phy_vsr_pkg;
  // ==========================================================
  // Types
  typedef logic [15:0] reg_word_t;
  typedef logic [4:0] reg_index_t;
  typedef logic [7:1] src_vec_t;
  typedef logic [2:0] speed_code_t;
endpackage

// ===== design/src_flag_if.sv
// Interface between the register bank and its event flag latch
`timescale 1ns/1ps
interface src_flag_if;
  phy_vsr_pkg::src_vec_t events;
  logic rd_clr;
  phy_vsr_pkg::src_vec_t mask;
  phy_vsr_pkg::src_vec_t flags;
  logic irq;
  modport latch (input events, input rd_clr, input mask, output flags, output irq);
  modport owner (output events, output rd_clr, output mask, input flags, input irq);
endinterface

// ===== design/line_energy_monitor.sv
// Line energy status with silence timeout and rise event
`timescale 1ns/1ps
`include "phy_vsr_params.svh"
module line_energy_monitor #(
  parameter int unsigned TIMEOUT_CYCLES = `ENERGY_TIMEOUT_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Raw energy detect and resulting status
  input wire logic energy_in,
  output logic present,
  output logic rise_evt
);
  localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

  logic [CW-1:0] quiet_q, quiet_d;
  logic present_q, present_d;

  // ==========================================================
  // Silence counter and status next values
  always_comb
  begin
    quiet_d = quiet_q;
    present_d = present_q;
    if (ce)
    begin
      if (energy_in)
      begin
        quiet_d = '0;
        present_d = 1'b1;
      end
      else if (present_q)
      begin
        if (quiet_q == LAST)
        begin
          present_d = 1'b0;
          quiet_d = '0;
        end
        else
        begin
          quiet_d = quiet_q + 1'b1;
        end
      end
    end
  end

  // Register silence state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      quiet_q <= '0;
      present_q <= `RST_LINE_ENERGY;
    end
    else
    begin
      quiet_q <= quiet_d;
      present_q <= present_d;
    end
  end

  // Return of energy is the latched event
  assign present = present_q;
  assign rise_evt = ce && energy_in && !present_q;

  // ==========================================================
  // Checks
  property p_energy_drop;
    @(posedge clk) disable iff (reset)
    (ce && present_q && !energy_in && quiet_q == LAST) |=> !present_q;
  endproperty
  a_energy_drop: assert property (p_energy_drop) else $error("energy status did not fall at timeout");

  property p_energy_rise;
    @(posedge clk) disable iff (reset)
    (ce && !present_q && energy_in) |-> rise_evt ##1 (present_q && !rise_evt);
  endproperty
  a_energy_rise: assert property (p_energy_rise) else $error("energy return not flagged once");
endmodule

// ===== design/event_flag_latch.sv
// Latched interrupt source flags with clear on read and masked interrupt level
`timescale 1ns/1ps
`include "phy_vsr_params.svh"
module event_flag_latch (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Flag bus to the register bank
  src_flag_if.latch flg
);
  phy_vsr_pkg::src_vec_t flags_q, flags_d;

  // ==========================================================
  // Flag next values: new events win over a read clear
  always_comb
  begin
    flags_d = flags_q;
    if (ce)
    begin
      flags_d = (flg.rd_clr ? `RST_FLAGS : flags_q) | flg.events;
    end
  end

  // Register flags
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flags_q <= `RST_FLAGS;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign flg.flags = flags_q;
  assign flg.irq = |(flags_q & flg.mask);

  // ==========================================================
  // Checks
  property p_flag_sticky;
    @(posedge clk) disable iff (reset)
    (!flg.rd_clr && flags_q[`BIT_SRC_LINK_DOWN]) |=> flags_q[`BIT_SRC_LINK_DOWN];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("latched flag dropped without a read");
endmodule

// ===== design/phy_vendor_status_irq_regs.sv
// Vendor control, status and interrupt register bank of a 10/100 transceiver
`timescale 1ns/1ps
`include "phy_vsr_params.svh"

module phy_vendor_status_irq_regs #(
  parameter int unsigned ENERGY_TIMEOUT_CYCLES = `ENERGY_TIMEOUT_CYCLES
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // Management register access
  input wire logic [4:0] MGMT_INDEX,
  input wire logic MGMT_WR,
  input wire logic MGMT_RD,
  input wire logic [15:0] MGMT_WDATA,
  output logic [15:0] MGMT_RDATA,
  output logic MGMT_RDATA_VALID,
  // Live status from the line side
  input wire logic AUTO_MDIX_IN,
  input wire logic POLARITY_REVERSED_IN,
  input wire logic NEG_DONE_IN,
  input wire logic [2:0] SPEED_DUPLEX_IN,
  input wire logic ENERGY_DETECT_IN,
  // Event pulses from the line side
  input wire logic NEG_COMPLETE_EV,
  input wire logic REMOTE_FAULT_EV,
  input wire logic LINK_DOWN_EV,
  input wire logic PARTNER_ACK_EV,
  input wire logic PAR_DET_FAULT_EV,
  input wire logic PAGE_RX_EV,
  // Controls to the line side
  output logic CROSSOVER_AUTO_DISABLE,
  output logic PAIR_SWAP,
  output logic HEARTBEAT_TEST_OFF,
  output logic ENC_4B5B_BYPASS,
  output logic LINE_ENERGY_PRESENT,
  // Interrupt level
  output logic IRQ
);
  // ==========================================================
  // Index decode helper
  function automatic logic is_idx(input phy_vsr_pkg::reg_index_t idx, input phy_vsr_pkg::reg_index_t target);
    is_idx = (idx == target);
  endfunction

  logic wr_ctl, wr_mask, wr_phy;
  logic rd_ctl, rd_src, rd_phy;
  logic energy_present, energy_evt;
  phy_vsr_pkg::src_vec_t ev_vec;

  // Qualified access strobes
  assign wr_ctl = CE && MGMT_WR && is_idx(MGMT_INDEX, `IDX_SPECIAL_CTL);
  assign wr_mask = CE && MGMT_WR && is_idx(MGMT_INDEX, `IDX_INT_MASK);
  assign wr_phy = CE && MGMT_WR && is_idx(MGMT_INDEX, `IDX_PHY_SPECIAL);
  assign rd_ctl = CE && MGMT_RD && is_idx(MGMT_INDEX, `IDX_SPECIAL_CTL);
  assign rd_src = CE && MGMT_RD && is_idx(MGMT_INDEX, `IDX_SRC_FLAGS);
  assign rd_phy = CE && MGMT_RD && is_idx(MGMT_INDEX, `IDX_PHY_SPECIAL);

  // ==========================================================
  // Energy monitor and flag latch
  line_energy_monitor #(
    .TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES)
  ) u_energy (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .energy_in(ENERGY_DETECT_IN),
    .present(energy_present),
    .rise_evt(energy_evt)
  );

  src_flag_if flg_bus ();

  event_flag_latch u_latch (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .flg(flg_bus.latch)
  );

  assign ev_vec = {energy_evt, NEG_COMPLETE_EV, REMOTE_FAULT_EV, LINK_DOWN_EV,
                   PARTNER_ACK_EV, PAR_DET_FAULT_EV, PAGE_RX_EV};
  assign flg_bus.events = ev_vec;
  assign flg_bus.rd_clr = rd_src;

  // ==========================================================
  // Writable configuration
  logic xover_off_q, xover_off_d;
  logic manual_sel_q, manual_sel_d;
  logic hb_off_q, hb_off_d;
  phy_vsr_pkg::src_vec_t mask_q, mask_d;
  logic enc_en_q, enc_en_d;

  // Configuration next values
  always_comb
  begin
    xover_off_d = xover_off_q;
    manual_sel_d = manual_sel_q;
    hb_off_d = hb_off_q;
    mask_d = mask_q;
    enc_en_d = enc_en_q;
    if (wr_ctl)
    begin
      xover_off_d = MGMT_WDATA[`BIT_XOVER_OFF];
      manual_sel_d = MGMT_WDATA[`BIT_MANUAL_SEL];
      hb_off_d = MGMT_WDATA[`BIT_HB_OFF];
    end
    if (wr_mask)
    begin
      mask_d = MGMT_WDATA[`SRC_MSB:`SRC_LSB];
    end
    if (wr_phy)
    begin
      enc_en_d = MGMT_WDATA[`BIT_ENC_EN];
    end
  end

  // Register configuration
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      xover_off_q <= `RST_XOVER_OFF;
      manual_sel_q <= `RST_MANUAL_SEL;
      hb_off_q <= `RST_HB_OFF;
      mask_q <= `RST_MASK;
      enc_en_q <= `RST_ENC_EN;
    end
    else
    begin
      xover_off_q <= xover_off_d;
      manual_sel_q <= manual_sel_d;
      hb_off_q <= hb_off_d;
      mask_q <= mask_d;
      enc_en_q <= enc_en_d;
    end
  end

  assign flg_bus.mask = mask_q;

  // ==========================================================
  // Effective pair assignment
  logic pair_swap_q, pair_swap_d;

  // Auto resolution unless overridden
  always_comb
  begin
    pair_swap_d = pair_swap_q;
    if (CE)
    begin
      pair_swap_d = xover_off_q ? manual_sel_q : AUTO_MDIX_IN;
    end
  end

  // Register pair assignment
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pair_swap_q <= 1'b0;
    end
    else
    begin
      pair_swap_q <= pair_swap_d;
    end
  end

  // ==========================================================
  // Read port
  phy_vsr_pkg::reg_word_t rdata_q, rdata_d;
  phy_vsr_pkg::reg_word_t rd_word;
  logic rvalid_q, rvalid_d;

  // Read word assembly, reserved and unmapped bits as zero
  always_comb
  begin
    rd_word = `RST_WORD;
    if (is_idx(MGMT_INDEX, `IDX_SPECIAL_CTL))
    begin
      rd_word[`BIT_XOVER_OFF] = xover_off_q;
      rd_word[`BIT_MANUAL_SEL] = manual_sel_q;
      rd_word[`BIT_HB_OFF] = hb_off_q;
      rd_word[`BIT_POL_REV] = POLARITY_REVERSED_IN;
    end
    else if (is_idx(MGMT_INDEX, `IDX_SRC_FLAGS))
    begin
      rd_word[`SRC_MSB:`SRC_LSB] = flg_bus.flags;
    end
    else if (is_idx(MGMT_INDEX, `IDX_INT_MASK))
    begin
      rd_word[`SRC_MSB:`SRC_LSB] = mask_q;
    end
    else if (is_idx(MGMT_INDEX, `IDX_PHY_SPECIAL))
    begin
      rd_word[`BIT_NEG_DONE] = NEG_DONE_IN;
      rd_word[`BIT_ENC_EN] = enc_en_q;
      rd_word[`SPD_MSB:`SPD_LSB] = SPEED_DUPLEX_IN;
    end
  end

  // Read data next values
  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = rvalid_q;
    if (CE)
    begin
      rvalid_d = MGMT_RD;
      if (MGMT_RD)
      begin
        rdata_d = rd_word;
      end
    end
  end

  // Register read data
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      rdata_q <= `RST_WORD;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================
  // Outputs
  assign MGMT_RDATA = rdata_q;
  assign MGMT_RDATA_VALID = rvalid_q;
  assign CROSSOVER_AUTO_DISABLE = xover_off_q;
  assign PAIR_SWAP = pair_swap_q;
  assign HEARTBEAT_TEST_OFF = hb_off_q;
  assign ENC_4B5B_BYPASS = !enc_en_q;
  assign LINE_ENERGY_PRESENT = energy_present;
  assign IRQ = flg_bus.irq;

  // ==========================================================
  // Checks
  sequence s_manual_write;
    wr_ctl && MGMT_WDATA[`BIT_XOVER_OFF];
  endsequence

  sequence s_mask_write_read;
    wr_mask ##1 (CE && MGMT_RD && is_idx(MGMT_INDEX, `IDX_INT_MASK));
  endsequence

  property p_swap_manual;
    @(posedge CLK) disable iff (RESET)
    s_manual_write ##1 CE |=> PAIR_SWAP == $past(MGMT_WDATA[`BIT_MANUAL_SEL], 2);
  endproperty
  a_swap_manual: assert property (p_swap_manual) else $error("manual pair select not applied");

  property p_manual_readback;
    @(posedge CLK) disable iff (RESET)
    wr_ctl ##1 rd_ctl |=> MGMT_RDATA[`BIT_MANUAL_SEL] == $past(MGMT_WDATA[`BIT_MANUAL_SEL], 2);
  endproperty
  a_manual_readback: assert property (p_manual_readback) else $error("pair select readback wrong");

  property p_hb_off;
    @(posedge CLK) disable iff (RESET)
    wr_ctl |=> HEARTBEAT_TEST_OFF == $past(MGMT_WDATA[`BIT_HB_OFF]);
  endproperty
  a_hb_off: assert property (p_hb_off) else $error("heartbeat control not taken");

  property p_polarity;
    @(posedge CLK) disable iff (RESET)
    rd_ctl |=> MGMT_RDATA_VALID && MGMT_RDATA[`BIT_POL_REV] == $past(POLARITY_REVERSED_IN);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity status readback wrong");

  property p_flag_seen;
    @(posedge CLK) disable iff (RESET)
    (CE && LINK_DOWN_EV) ##1 rd_src |=> MGMT_RDATA[`BIT_SRC_LINK_DOWN];
  endproperty
  a_flag_seen: assert property (p_flag_seen) else $error("link down flag not reported");

  property p_flag_held;
    @(posedge CLK) disable iff (RESET)
    (CE && REMOTE_FAULT_EV) ##1 (!rd_src) [*3] ##1 rd_src |=> MGMT_RDATA[`BIT_SRC_REMOTE];
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("remote fault flag not held");

  property p_mask_readback;
    @(posedge CLK) disable iff (RESET)
    s_mask_write_read |=> MGMT_RDATA[`SRC_MSB:`SRC_LSB] == $past(MGMT_WDATA[`SRC_MSB:`SRC_LSB], 2)
      && !MGMT_RDATA[0];
  endproperty
  a_mask_readback: assert property (p_mask_readback) else $error("mask readback wrong");

  property p_neg_done;
    @(posedge CLK) disable iff (RESET)
    rd_phy |=> MGMT_RDATA[`BIT_NEG_DONE] == $past(NEG_DONE_IN);
  endproperty
  a_neg_done: assert property (p_neg_done) else $error("negotiation done readback wrong");

  property p_coder_reset;
    @(posedge CLK) disable iff (RESET)
    $past(RESET) |-> !ENC_4B5B_BYPASS;
  endproperty
  a_coder_reset: assert property (p_coder_reset) else $error("coder not enabled after reset");

  property p_speed;
    @(posedge CLK) disable iff (RESET)
    rd_phy |=> MGMT_RDATA[`SPD_MSB:`SPD_LSB] == $past(SPEED_DUPLEX_IN);
  endproperty
  a_speed: assert property (p_speed) else $error("speed code readback wrong");

  property p_irq_set;
    @(posedge CLK) disable iff (RESET)
    (CE && LINK_DOWN_EV && mask_q[`BIT_SRC_LINK_DOWN] && !wr_mask) |=> IRQ;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled event gave no interrupt");

  property p_read_clears;
    @(posedge CLK) disable iff (RESET)
    (rd_src && ev_vec == `RST_FLAGS) ##1 (rd_src && ev_vec == `RST_FLAGS) |=> MGMT_RDATA[`SRC_MSB:`SRC_LSB] == `RST_FLAGS
      && !IRQ;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags not cleared by read");

  property p_set_wins;
    @(posedge CLK) disable iff (RESET)
    (rd_src && PAGE_RX_EV) ##1 rd_src |=> MGMT_RDATA[`BIT_SRC_PAGE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in clearing read");
endmodule

// ===== bench/mgmt_master.sv
// Station management controller model driving the register port
`timescale 1ns/1ps
module mgmt_master #(
  parameter bit MII_MODE = 1'b1
) (
  // Clock
  input wire logic clk,
  // Register access strobes
  output logic [4:0] index,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata
);
  // Idle bus at time zero
  initial
  begin
    index = 5'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end

  // One write strobe, launched just after an edge
  task automatic wr_reg(input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    #1;
    if (i == 5'h1f && !MII_MODE)
    begin
      d[6] = 1'b1;
    end
    index = i;
    wdata = d;
    wr = 1'b1;
    rd = 1'b0;
  endtask

  // One read strobe; write data is meaningless meanwhile
  task automatic rd_reg(input logic [4:0] i);
    @(posedge clk);
    #1;
    index = i;
    wdata = ~wdata;
    rd = 1'b1;
    wr = 1'b0;
  endtask

  // Release strobes and scramble the index while idle
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      rd = 1'b0;
      wr = 1'b0;
      index = ~index;
    end
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench of the vendor register bank
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module tb_top;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic CE = 1'b1;
  logic [4:0] idx;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic mdix = 1'b0;
  logic pol = 1'b0;
  logic neg = 1'b0;
  logic energy = 1'b1;
  logic [2:0] spd = 3'h1;
  logic [6:1] ev = 6'h00;
  logic xoff, swap, hboff, byp, present, irq;
  logic [15:0] q[$];
  logic [15:0] mask;
  logic [15:0] exp_w;
  logic [2:0] codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
  int err_total = 0;
  int checked = 0;

  // Clock generation
  always #50 CLK = ~CLK;

  // ==========================================================
  // Design and controller model
  phy_vendor_status_irq_regs #(.ENERGY_TIMEOUT_CYCLES(8)) i_phy_vendor_status_irq_regs (
    .CLK(CLK), .RESET(RESET), .CE(CE), .MGMT_INDEX(idx), .MGMT_WR(wr), .MGMT_RD(rd),
    .MGMT_WDATA(wdata), .MGMT_RDATA(rdata), .MGMT_RDATA_VALID(rvalid), .AUTO_MDIX_IN(mdix),
    .POLARITY_REVERSED_IN(pol), .NEG_DONE_IN(neg), .SPEED_DUPLEX_IN(spd), .ENERGY_DETECT_IN(energy),
    .NEG_COMPLETE_EV(ev[6]), .REMOTE_FAULT_EV(ev[5]), .LINK_DOWN_EV(ev[4]), .PARTNER_ACK_EV(ev[3]),
    .PAR_DET_FAULT_EV(ev[2]), .PAGE_RX_EV(ev[1]), .CROSSOVER_AUTO_DISABLE(xoff), .PAIR_SWAP(swap),
    .HEARTBEAT_TEST_OFF(hboff), .ENC_4B5B_BYPASS(byp), .LINE_ENERGY_PRESENT(present), .IRQ(irq));
  mgmt_master i_mgmt_master (.clk(CLK), .index(idx), .wr(wr), .rd(rd), .wdata(wdata));

  // Verdict and end of run
  task end_of_test;
    if (err_total == 0 && checked > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Note the expected word, then issue the read
  task automatic rd_chk(input logic [4:0] i, input logic [15:0] e);
    q.push_back(e);
    i_mgmt_master.rd_reg(i);
  endtask

  // Read monitor takes the oldest note for each answer
  always @(negedge CLK)
  begin
    if (rvalid === 1'b1)
    begin
      exp_w = (q.size() > 0) ? q.pop_front() : ~rdata;
      `CHK(rdata, exp_w)
    end
  end

  // Hang guard
  initial
  begin
    #(100 * 5000);
    err_total++;
    end_of_test();
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    void'($urandom(9));
    repeat (20) @(posedge CLK);
    #1;
    RESET = 1'b0;
    // Reset values, unmapped index
    rd_chk(5'h1b, 16'h0000);
    rd_chk(5'h1d, 16'h0000);
    rd_chk(5'h1e, 16'h0000);
    rd_chk(5'h1f, 16'h0044);
    rd_chk(5'h00, 16'h0000);
    i_mgmt_master.idle(1);
    `CHK({xoff, swap, hboff, byp, present, irq}, 6'h02)
    // Control bits, live polarity, manual pair
    pol = 1'($urandom);
    i_mgmt_master.wr_reg(5'h1b, 16'hffff);
    i_mgmt_master.idle(2);
    `CHK({xoff, swap, hboff}, 3'h7)
    rd_chk(5'h1b, 16'ha800 | {11'h000, pol, 4'h0});
    // Manual bit ignored while automatic crossover runs
    i_mgmt_master.wr_reg(5'h1b, 16'h2000);
    mdix = 1'b0;
    i_mgmt_master.idle(2);
    `CHK({xoff, swap, hboff}, 3'h0)
    mdix = 1'b1;
    i_mgmt_master.idle(2);
    `CHK(swap, 1'b1)
    // Speed codes and negotiation done
    neg = 1'($urandom);
    foreach (codes[k])
    begin
      spd = codes[k];
      rd_chk(5'h1f, {3'h0, neg, 5'h00, 1'b1, 1'b0, codes[k], 2'h0});
      // Let the read be taken before the code moves on
      i_mgmt_master.idle(1);
    end
    i_mgmt_master.wr_reg(5'h1f, 16'h0000);
    rd_chk(5'h1f, {3'h0, neg, 5'h00, 1'b0, 1'b0, spd, 2'h0});
    `CHK(byp, 1'b1)
    i_mgmt_master.wr_reg(5'h1f, 16'hffff);
    rd_chk(5'h1f, {3'h0, neg, 5'h00, 1'b1, 1'b0, spd, 2'h0});
    i_mgmt_master.wr_reg(5'h1d, 16'hffff);
    rd_chk(5'h1d, 16'h0000);
    // Random mask, each of the six event pulse inputs in turn
    mask = 16'($urandom);
    i_mgmt_master.wr_reg(5'h1e, mask);
    rd_chk(5'h1e, mask & 16'h00fe);
    for (int i = 1; i <= 6; i++)
    begin
      ev[i] = 1'b1;
      i_mgmt_master.idle(1);
      ev = 6'h00;
      i_mgmt_master.idle(1);
      `CHK(irq, mask[i])
      rd_chk(5'h1d, 16'(1 << i));
      rd_chk(5'h1d, 16'h0000);
      i_mgmt_master.idle(1);
      `CHK(irq, 1'b0)
    end
    // Event in the clearing read cycle survives
    rd_chk(5'h1d, 16'h0000);
    ev[4] = 1'b1;
    i_mgmt_master.idle(1);
    ev = 6'h00;
    rd_chk(5'h1d, 16'h0010);
    // Nothing taken while the clock enable is low
    i_mgmt_master.idle(2);
    CE = 1'b0;
    ev[1] = 1'b1;
    i_mgmt_master.wr_reg(5'h1e, ~mask);
    i_mgmt_master.idle(1);
    ev = 6'h00;
    CE = 1'b1;
    rd_chk(5'h1e, mask & 16'h00fe);
    rd_chk(5'h1d, 16'h0000);
    // Energy silence timeout and return event
    i_mgmt_master.wr_reg(5'h1e, 16'h0080);
    i_mgmt_master.idle(1);
    energy = 1'b0;
    i_mgmt_master.idle(6);
    `CHK(present, 1'b1)
    i_mgmt_master.idle(4);
    `CHK({present, irq}, 2'h0)
    energy = 1'b1;
    i_mgmt_master.idle(2);
    `CHK({present, irq}, 2'h3)
    rd_chk(5'h1d, 16'h0080);
    i_mgmt_master.idle(1);
    `CHK(irq, 1'b0)
    // Reset in mid-run restores defaults
    i_mgmt_master.wr_reg(5'h1f, 16'h0000);
    pol = 1'b0;
    RESET = 1'b1;
    i_mgmt_master.idle(2);
    RESET = 1'b0;
    rd_chk(5'h1e, 16'h0000);
    rd_chk(5'h1b, 16'h0000);
    rd_chk(5'h1f, {3'h0, neg, 5'h00, 1'b1, 1'b0, spd, 2'h0});
    i_mgmt_master.idle(3);
    `CHK({byp, present, xoff}, 3'h2)
    `CHK(q.size(), 0)
    end_of_test();
  end
endmodule
